//--- rtl/sct_pkg.sv
// Purpose: shared constants for the sdram command-timing device and controller ends
// Assumes: one 20 MHz clock, period 50 ns
// Notes:   ns minimums become cycle counts rounded up
`default_nettype none
package sct_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ        = 20000000;
  localparam int ADDR_W        = 12;
  localparam int BANK_W        = 2;
  localparam int COL_W         = 8;
  localparam int DATA_W        = 16;
  localparam int NBANK         = 4;
  localparam int CNT_W         = 16;
  // read latency choices
  localparam logic [1:0] LAT_TWO   = 2'h2;
  localparam logic [1:0] LAT_THREE = 2'h3;
  // cycle figures
  localparam int T_CCD_CYC     = 1;
  localparam int T_DQZ_CYC     = 2;
  localparam int T_DAL3_CYC    = 5;
  localparam int T_DAL2_CYC    = 4;
  localparam int T_DPL_CYC     = 2;
  localparam int T_BDL_CYC     = 1;
  localparam int T_CDL_CYC     = 1;
  localparam int T_MRD_CYC     = 2;
  localparam int T_ROH3_CYC    = 3;
  localparam int T_ROH2_CYC    = 2;
  // ns minimums, slowest grade, and derived cycle counts
  localparam int T_RC_NS       = 63;
  localparam int T_RAS_NS      = 42;
  localparam int T_RAS_MAX_NS  = 100000;
  localparam int T_RP_NS       = 15;
  localparam int T_RCD_NS      = 15;
  localparam int T_RRD_NS      = 14;
  localparam int T_XSR_NS      = 70;
  localparam int T_CKA_EXTRA_NS = 3;
  localparam int T_RC_CYC   = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RAS_CYC  = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RAS_MAX_CYC = T_RAS_MAX_NS / CLK_PERIOD_NS;
  localparam int T_RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RRD_CYC  = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_XSR_CYC  = (T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKA_CYC  = 1 + (T_CKA_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refresh: 4096 rows in 64 ms
  localparam int REF_ROWS      = 4096;
  localparam int T_REF_MS      = 64;
  localparam int T_REFI_CYC    = (T_REF_MS * (CLK_HZ / 1000)) / REF_ROWS;
  // power-up wait
  localparam int T_PWRUP_US    = 200;
  localparam int T_PWRUP_CYC   = T_PWRUP_US * (CLK_HZ / 1000000);
  // command encodings {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SCT_CMD_NOP   = 4'h7,
    SCT_CMD_ACT   = 4'h3,
    SCT_CMD_READ  = 4'h5,
    SCT_CMD_WRITE = 4'h4,
    SCT_CMD_STOP  = 4'h6,
    SCT_CMD_PRE   = 4'h2,
    SCT_CMD_REF   = 4'h1,
    SCT_CMD_MODE  = 4'h0,
    SCT_CMD_DESEL = 4'h8
  } sct_cmd_t;
  localparam int AP_BIT = 10;
  localparam int MODE_LAT_LSB = 4;
  localparam int MODE_LAT_W   = 3;
endpackage : sct_pkg
`default_nettype wire

//--- rtl/sct_if.sv
// Purpose: link between sdram controller and device ends
// Assumes: single clock shared by both ends
// Notes:   data pins are three signals per end
`timescale 1ns/10ps
`default_nettype none
interface sct_if;
  logic [3:0]                    cmd;
  logic [sct_pkg::BANK_W-1:0]    bank;
  logic [sct_pkg::ADDR_W-1:0]    addr;
  logic                          cke;
  logic                          dqm;
  logic [sct_pkg::DATA_W-1:0]    dq_ctl;
  logic                          dq_ctl_oe_n;
  logic [sct_pkg::DATA_W-1:0]    dq_dev;
  logic                          dq_dev_oe_n;
  logic [sct_pkg::DATA_W-1:0]    dq;
  assign dq = !dq_dev_oe_n ? dq_dev : dq_ctl;
  modport dev (input cmd, bank, addr, cke, dqm, dq, output dq_dev, dq_dev_oe_n);
  modport ctl (output cmd, bank, addr, cke, dqm, dq_ctl, dq_ctl_oe_n, input dq);
endinterface : sct_if
`default_nettype wire

//--- rtl/sct_dev.sv
// Purpose: sdram device end: command decode, memory, read pipe, mask
// Assumes: controller keeps all spacing figures
// Notes:   burst length one per column command
`timescale 1ns/10ps
`default_nettype none
module sct_dev #(
  parameter int ROW_BITS = 4,
  parameter int COL_BITS = 4
) (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  sct_if.dev                              link,
  output logic [1:0]                      read_latency_setting_out,
  output logic                            suspended_out
);
  localparam int AW = sct_pkg::BANK_W + ROW_BITS + COL_BITS;
  logic [sct_pkg::DATA_W-1:0] mem [0:(1<<AW)-1];
  logic [1:0]                 read_latency_setting_reg;
  logic                       susp_reg;
  logic [ROW_BITS-1:0]        row_reg [0:sct_pkg::NBANK-1];
  logic [sct_pkg::DATA_W-1:0] pipe_d_reg [0:2];
  logic [2:0]                 pipe_v_reg;
  logic [1:0]                 dqm_reg;
  logic                       live;
  sct_pkg::sct_cmd_t          cmd;
  logic [AW-1:0]              col_addr;
  logic                       is_read;
  logic                       is_pre;
  logic                       rd_slot;

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign cmd      = sct_pkg::sct_cmd_t'(link.cmd);
  assign live     = link.cke && !susp_reg;
  assign col_addr = {link.bank, row_reg[link.bank], link.addr[COL_BITS-1:0]};
  assign is_read  = live && cmd == sct_pkg::SCT_CMD_READ;
  assign is_pre   = live && cmd == sct_pkg::SCT_CMD_PRE;
  assign read_latency_setting_out = read_latency_setting_reg;
  assign suspended_out = susp_reg;

  ////////////////////////////////////////////////////////////////////////
  // clock-enable: sample low blocks that cycle's command and freezes the read pipe next cycle, high resumes next cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      susp_reg <= 1'b0;
    end else begin
      susp_reg <= !link.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode register and row latches
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      read_latency_setting_reg <= sct_pkg::LAT_THREE;
      for (int i = 0; i < sct_pkg::NBANK; i++) begin
        row_reg[i] <= '0;
      end
    end else if (live) begin
      if (cmd == sct_pkg::SCT_CMD_MODE) begin
        if (link.addr[sct_pkg::MODE_LAT_LSB +: sct_pkg::MODE_LAT_W] ==
            {1'b0, sct_pkg::LAT_TWO}) begin
          read_latency_setting_reg <= sct_pkg::LAT_TWO;
        end else begin
          read_latency_setting_reg <= sct_pkg::LAT_THREE;
        end
      end
      if (cmd == sct_pkg::SCT_CMD_ACT) begin
        row_reg[link.bank] <= link.addr[ROW_BITS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write: data with command, mask same cycle
  always_ff @(posedge clk_in) begin
    if (live && cmd == sct_pkg::SCT_CMD_WRITE && !link.dqm) begin
      mem[col_addr] <= link.dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read pipe: stage 0 taken at command, out at latency 2 or 3
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pipe_v_reg <= '0;
      dqm_reg    <= '0;
      for (int i = 0; i < 3; i++) begin
        pipe_d_reg[i] <= '0;
      end
    end else begin
      dqm_reg <= {dqm_reg[0], link.dqm};
      if (!susp_reg) begin
        pipe_v_reg[0] <= is_read;
        pipe_d_reg[0] <= mem[col_addr];
        pipe_v_reg[1] <= pipe_v_reg[0];
        pipe_d_reg[1] <= pipe_d_reg[0];
        pipe_v_reg[2] <= pipe_v_reg[1];
        pipe_d_reg[2] <= pipe_d_reg[1];
        if (is_pre) begin
          // single-word reads already issued still finish before the 3/2 float point
          pipe_v_reg[0] <= 1'b0;
        end
      end
    end
  end

  assign rd_slot = (read_latency_setting_reg == sct_pkg::LAT_THREE) ? pipe_v_reg[2]
                                                                    : pipe_v_reg[1];
  assign link.dq_dev = (read_latency_setting_reg == sct_pkg::LAT_THREE) ? pipe_d_reg[2]
                                                                        : pipe_d_reg[1];
  assign link.dq_dev_oe_n = !(rd_slot && !dqm_reg[1]);
endmodule : sct_dev
`default_nettype wire

//--- rtl/sct_ctl.sv
// Purpose: controller end: issues commands keeping device spacing
// Assumes: one request at a time, single-word accesses
// Notes:   counts from ns rounded up
`timescale 1ns/10ps
`default_nettype none
module sct_ctl #(
  parameter int PWRUP_CYC = sct_pkg::T_PWRUP_CYC,
  parameter int REFI_CYC  = sct_pkg::T_REFI_CYC,
  parameter logic [1:0] LATENCY = sct_pkg::LAT_THREE
) (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  sct_if.ctl                               link,
  input  wire logic                        req_valid_in,
  input  wire logic                        req_write_in,
  input  wire logic [sct_pkg::BANK_W-1:0]  req_bank_in,
  input  wire logic [sct_pkg::ADDR_W-1:0]  req_row_in,
  input  wire logic [sct_pkg::COL_W-1:0]   req_col_in,
  input  wire logic [sct_pkg::DATA_W-1:0]  req_wdata_in,
  output logic                             req_ready_out,
  output logic                             rd_valid_out,
  output logic [sct_pkg::DATA_W-1:0]       rd_data_out
);
  typedef enum {S_PWR, S_PRE, S_MODE, S_IDLE, S_ACT, S_COL, S_PRECH,
                S_WAIT} sct_state_t;
  sct_state_t                  st_reg;
  sct_state_t                  ret_reg;
  logic [31:0]                 wait_reg;
  logic [31:0]                 refc_reg;
  logic                        wr_reg;
  logic [sct_pkg::BANK_W-1:0]  bank_reg;
  logic [sct_pkg::ADDR_W-1:0]  row_reg;
  logic [sct_pkg::COL_W-1:0]   col_reg;
  logic [sct_pkg::DATA_W-1:0]  wd_reg;
  logic [3:0]                  rdv_reg;
  logic [3:0]                  cmd_reg;
  logic [sct_pkg::ADDR_W-1:0]  addr_reg;
  logic                        oe_n_reg;

  assign link.cke  = 1'b1;
  assign link.dqm  = 1'b0;
  assign link.cmd  = cmd_reg;
  assign link.bank = bank_reg;
  assign link.addr = addr_reg;
  assign link.dq_ctl = wd_reg;
  assign link.dq_ctl_oe_n = oe_n_reg;
  assign req_ready_out = st_reg == S_IDLE && refc_reg < 32'(REFI_CYC);

  ////////////////////////////////////////////////////////////////////////
  // sequencer; each wait is spacing minus one issue cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= S_PWR; ret_reg <= S_IDLE; wait_reg <= '0;
      cmd_reg <= sct_pkg::SCT_CMD_NOP; addr_reg <= '0; bank_reg <= '0;
      oe_n_reg <= 1'b1; wr_reg <= 1'b0; row_reg <= '0; col_reg <= '0; wd_reg <= '0;
    end else begin
      cmd_reg  <= sct_pkg::SCT_CMD_NOP;
      oe_n_reg <= 1'b1;
      unique case (st_reg)
        S_PWR: begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg >= 32'(PWRUP_CYC)) st_reg <= S_PRE;
        end
        S_PRE: begin
          cmd_reg <= sct_pkg::SCT_CMD_PRE;
          addr_reg[sct_pkg::AP_BIT] <= 1'b1;
          wait_reg <= 32'(sct_pkg::T_RP_CYC);
          ret_reg <= S_MODE; st_reg <= S_WAIT;
        end
        S_MODE: begin
          cmd_reg <= sct_pkg::SCT_CMD_MODE;
          addr_reg <= '0;
          addr_reg[sct_pkg::MODE_LAT_LSB +: 2] <= LATENCY;
          wait_reg <= 32'(sct_pkg::T_MRD_CYC);
          ret_reg <= S_IDLE; st_reg <= S_WAIT;
        end
        S_IDLE: begin
          if (refc_reg >= 32'(REFI_CYC)) begin
            cmd_reg <= sct_pkg::SCT_CMD_REF;
            wait_reg <= 32'(sct_pkg::T_RC_CYC);
            ret_reg <= S_IDLE; st_reg <= S_WAIT;
          end else if (req_valid_in) begin
            wr_reg <= req_write_in; bank_reg <= req_bank_in;
            row_reg <= req_row_in; col_reg <= req_col_in; wd_reg <= req_wdata_in;
            st_reg <= S_ACT;
          end
        end
        S_ACT: begin
          cmd_reg <= sct_pkg::SCT_CMD_ACT; addr_reg <= row_reg;
          wait_reg <= 32'(sct_pkg::T_RCD_CYC);
          ret_reg <= S_COL; st_reg <= S_WAIT;
        end
        S_COL: begin
          cmd_reg <= wr_reg ? sct_pkg::SCT_CMD_WRITE : sct_pkg::SCT_CMD_READ;
          addr_reg <= {{(sct_pkg::ADDR_W-sct_pkg::COL_W){1'b0}}, col_reg};
          oe_n_reg <= !wr_reg;
          // precharge after write recovery / ras minimum / read data out
          wait_reg <= 32'(wr_reg ? sct_pkg::T_DPL_CYC
                                 : sct_pkg::T_RAS_CYC + 32'(LATENCY));
          ret_reg <= S_PRECH; st_reg <= S_WAIT;
        end
        S_PRECH: begin
          cmd_reg <= sct_pkg::SCT_CMD_PRE; addr_reg <= '0;
          wait_reg <= 32'(sct_pkg::T_RP_CYC + sct_pkg::T_RC_CYC);
          ret_reg <= S_IDLE; st_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (wait_reg <= 32'h1) st_reg <= ret_reg;
          else wait_reg <= wait_reg - 32'h1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh interval and read capture
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refc_reg <= '0; rdv_reg <= '0; rd_valid_out <= 1'b0; rd_data_out <= '0;
    end else begin
      if (cmd_reg == sct_pkg::SCT_CMD_REF) refc_reg <= '0;
      else if (st_reg != S_PWR) refc_reg <= refc_reg + 32'h1;
      rdv_reg <= {rdv_reg[2:0], cmd_reg == sct_pkg::SCT_CMD_READ};
      rd_valid_out <= rdv_reg[LATENCY - 2'h1];
      rd_data_out <= link.dq;
    end
  end
endmodule : sct_ctl
`default_nettype wire

//--- sim/sct_monitor.sv
// Purpose: interface checks on the main controller-to-device link
// Assumes: controller programs read latency three
// Notes:   plain inputs mirror the interface signals
`timescale 1ns/10ps
`default_nettype none
module sct_monitor #(
  parameter int PWRUP_CYC = 4
) (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [3:0]  cmd,
  input wire logic [1:0]  bank,
  input wire logic [11:0] addr,
  input wire logic        cke,
  input wire logic        dqm,
  input wire logic        dq_ctl_oe_n,
  input wire logic        dq_dev_oe_n
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [15:0] up_cnt_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_cnt_reg <= 16'h0;
    end else if (up_cnt_reg < 16'(PWRUP_CYC)) begin
      up_cnt_reg <= up_cnt_reg + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd;
    cmd == sct_pkg::SCT_CMD_READ && cke ##1 !dqm;
  endsequence
  sequence s_ap_wr;
    cmd == sct_pkg::SCT_CMD_WRITE && addr[sct_pkg::AP_BIT];
  endsequence
  a_read_data_lat: assert property (s_rd |-> ##2 !dq_dev_oe_n)
    else $error("read data not driven three cycles after read");
  a_dev_drive_cause: assert property (!dq_dev_oe_n |-> $past(cmd, 3) == sct_pkg::SCT_CMD_READ)
    else $error("device drives data with no read three cycles back");
  a_write_data_same: assert property (cmd == sct_pkg::SCT_CMD_WRITE |-> !dq_ctl_oe_n)
    else $error("write data not driven with write command");
  a_no_bus_clash: assert property (!(!dq_ctl_oe_n && !dq_dev_oe_n))
    else $error("both ends drive data");
  a_data_prech_gap: assert property (cmd == sct_pkg::SCT_CMD_WRITE |=> cmd != sct_pkg::SCT_CMD_PRE)
    else $error("precharge one cycle after write data");
  a_mode_load_gap: assert property (cmd == sct_pkg::SCT_CMD_MODE |=>
    !(cmd inside {sct_pkg::SCT_CMD_ACT, sct_pkg::SCT_CMD_REF}))
    else $error("activate or refresh one cycle after mode load");
  a_same_bank_act: assert property (cmd == sct_pkg::SCT_CMD_ACT |=>
    !(cmd == sct_pkg::SCT_CMD_ACT && bank == $past(bank)))
    else $error("same bank activated on next cycle");
  a_ap_write_wait: assert property (s_ap_wr |=>
    !(cmd inside {sct_pkg::SCT_CMD_ACT, sct_pkg::SCT_CMD_REF}) [*4])
    else $error("activate or refresh too soon after auto-precharge write");
  a_pwrup_quiet: assert property (up_cnt_reg < 16'(PWRUP_CYC) |->
    cmd inside {sct_pkg::SCT_CMD_NOP, sct_pkg::SCT_CMD_DESEL})
    else $error("command issued during power-up wait");
  a_cke_resume: assert property ($rose(cke) |->
    cmd inside {sct_pkg::SCT_CMD_NOP, sct_pkg::SCT_CMD_DESEL})
    else $error("command issued as clock enable rises");
endmodule : sct_monitor
`default_nettype wire

//--- sim/tb_sdram_command_timing.sv
// Purpose: bench for the controller and device ends of the sdram link
// Assumes: 20 MHz clock; main link latency three, second link latency two
// Notes:   second link is driven by the bench in the controller's place
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_command_timing;
  logic        clk_in = 1'b0;
  logic        resetn_in;
  logic        req_valid_in, req_write_in, req_ready_out, rd_valid_out, susp_b;
  logic [1:0]  req_bank_in, lat_a, lat_b;
  logic [11:0] req_row_in;
  logic [7:0]  req_col_in;
  logic [15:0] req_wdata_in, rd_data_out;
  logic [31:0] seed;
  logic [15:0] exp_rd[$], exp_dq[$], mem_w[8];
  logic [3:0]  row_w[8];
  int          fail_count, num_checks;
  sct_if link ();
  sct_if link2 ();
  always #25 clk_in = ~clk_in;
  sct_ctl #(.PWRUP_CYC(4), .REFI_CYC(50), .LATENCY(sct_pkg::LAT_THREE)) u_sct_ctl (
    .clk_in(clk_in), .resetn_in(resetn_in), .link(link), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_bank_in(req_bank_in), .req_row_in(req_row_in),
    .req_col_in(req_col_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));
  sct_dev u_sct_dev (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .read_latency_setting_out(lat_a), .suspended_out());
  sct_dev u_sct_dev_fault (.clk_in(clk_in), .resetn_in(resetn_in), .link(link2),
    .read_latency_setting_out(lat_b), .suspended_out(susp_b));
  sct_monitor #(.PWRUP_CYC(4)) u_sct_monitor (.clk_in(clk_in), .resetn_in(resetn_in),
    .cmd(link.cmd), .bank(link.bank), .addr(link.addr), .cke(link.cke), .dqm(link.dqm),
    .dq_ctl_oe_n(link.dq_ctl_oe_n), .dq_dev_oe_n(link.dq_dev_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic req(input logic w, input logic [1:0] b, input logic [3:0] r,
                     input logic [3:0] c, input logic [15:0] d);
    int n = 0;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_bank_in  <= b;
    req_row_in   <= {8'h0, r};
    req_col_in   <= {4'h0, c};
    req_wdata_in <= d;
    do begin
      @(negedge clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 400);
    if (n >= 400) begin
      chk("request accepted", 16'h1, 16'h0);
      complete_run();
    end
    @(posedge clk_in);
    req_valid_in <= 1'b0;
  endtask : req
  task automatic dv(input sct_pkg::sct_cmd_t c, input logic [11:0] a, input logic m,
                    input logic k, input logic [15:0] d);
    @(posedge clk_in);
    link2.cmd         <= c;
    link2.addr        <= a;
    link2.dqm         <= m;
    link2.cke         <= k;
    link2.dq_ctl      <= (c == sct_pkg::SCT_CMD_WRITE) ? d : ~link2.dq_ctl;
    link2.dq_ctl_oe_n <= (c != sct_pkg::SCT_CMD_WRITE);
  endtask : dv
  task automatic drain();
    int n = 0;
    while (exp_rd.size() + exp_dq.size() != 0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 2000) begin
      chk("reads drained", 16'h0, 16'h1);
      complete_run();
    end
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1) begin
      if (exp_rd.size() == 0) chk("ctl extra read", 16'h0, 16'hffff);
      else chk("ctl read data", exp_rd.pop_front(), rd_data_out);
    end
    if (link2.dq_dev_oe_n === 1'b0) begin
      if (exp_dq.size() == 0) chk("dev extra read", 16'h0, 16'hffff);
      else chk("dev read data", exp_dq.pop_front(), link2.dq_dev);
    end
  end
  initial begin
    seed = 32'h2be8;
    resetn_in = 1'b0;
    {req_valid_in, req_write_in, req_bank_in, req_row_in, req_col_in, req_wdata_in} = '0;
    {link2.bank, link2.addr, link2.dq_ctl} = '0;
    {link2.cke, link2.dqm, link2.dq_ctl_oe_n} = 3'h7;
    link2.cmd = sct_pkg::SCT_CMD_NOP;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      mem_w[i] = seed[15:0];
      row_w[i] = seed[19:16];
      req(1'b1, i[1:0], row_w[i], i[3:0], mem_w[i]);
    end
    for (int i = 0; i < 8; i++) begin
      exp_rd.push_back(mem_w[i]);
      req(1'b0, i[1:0], row_w[i], i[3:0], 16'h0);
    end
    drain();
    chk("main latency", {14'h0, sct_pkg::LAT_THREE}, {14'h0, lat_a});
    $display("test main link done");
    seed = xs(seed);
    dv(sct_pkg::SCT_CMD_MODE, 12'h020, 1'b0, 1'b1, 16'h0);
    repeat (2) dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_ACT, 12'h000, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_WRITE, 12'h002, 1'b0, 1'b1, seed[15:0]);
    dv(sct_pkg::SCT_CMD_WRITE, 12'h001, 1'b0, 1'b1, seed[31:16]);
    dv(sct_pkg::SCT_CMD_WRITE, 12'h002, 1'b1, 1'b1, ~seed[15:0]);
    exp_dq.push_back(seed[31:16]);
    exp_dq.push_back(seed[15:0]);
    dv(sct_pkg::SCT_CMD_READ, 12'h001, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_READ, 12'h002, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_READ, 12'h001, 1'b1, 1'b1, 16'h0);
    repeat (3) dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b0, 16'h0);
    dv(sct_pkg::SCT_CMD_WRITE, 12'h001, 1'b0, 1'b0, ~seed[31:16]);
    dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b0, 16'h0);
    @(negedge clk_in);
    chk("suspended", 16'h1, {15'h0, susp_b});
    repeat (3) dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b1, 16'h0);
    @(negedge clk_in);
    chk("resumed", 16'h0, {15'h0, susp_b});
    exp_dq.push_back(seed[31:16]);
    dv(sct_pkg::SCT_CMD_READ, 12'h001, 1'b0, 1'b1, 16'h0);
    dv(sct_pkg::SCT_CMD_NOP, 12'h0, 1'b0, 1'b1, 16'h0);
    drain();
    chk("second latency", {14'h0, sct_pkg::LAT_TWO}, {14'h0, lat_b});
    $display("test second link done");
    complete_run();
  end
endmodule : tb_sdram_command_timing
`default_nettype wire
